// ---- hw/fpp_core.sv ----
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module fpp_core
(
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire fpp_pkg::fpp_op_t op_in,
   output fpp_pkg::fpp_res_t res_out,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   fpp_pkg::fpp_state_t s_q;
   fpp_pkg::fpp_state_t s_d;

   function automatic logic [6:0] lzc68(input logic [67:0] v);
      logic found;
      lzc68 = 7'h44;
      found = 1'b0;
      for (int i = 67; i >= 0; i--)
      begin
         if (!found && v[i])
         begin
            lzc68 = 7'(67 - i);
            found = 1'b1;
         end
      end
   endfunction

   function automatic logic is_nan(input fpp_pkg::fpp_ext_t v);
      is_nan = (v.exp == fpp_pkg::EXP_ALL_ONES) && (v.mant[62:0] != 63'h0);
   endfunction

   function automatic logic is_inf(input fpp_pkg::fpp_ext_t v);
      is_inf = (v.exp == fpp_pkg::EXP_ALL_ONES) && (v.mant[62:0] == 63'h0);
   endfunction

   function automatic logic is_zero(input fpp_pkg::fpp_ext_t v);
      is_zero = (v.exp != fpp_pkg::EXP_ALL_ONES) && (v.mant == 64'h0);
   endfunction

   // denormal and unnormal inputs shifted up, exponent extended below field range
   function automatic logic [81:0] norm_op(input fpp_pkg::fpp_ext_t v);
      logic signed [17:0] e;
      logic [6:0] n;
      e = (v.exp == 15'h0000) ? 18'sh00001 : $signed({3'h0, v.exp});
      n = lzc68({v.mant, 4'h0});
      if (v.mant == 64'h0)
      begin
         norm_op = {18'sh20000, 64'h0};
      end
      else
      begin
         norm_op = {18'(e - $signed({11'h000, n})), 64'(v.mant << n)};
      end
   endfunction

   fpp_pkg::fpp_ext_t src, dst, res_v;
   logic src_nan, dst_nan, src_signaling_not_a_number_flag, dst_signaling_not_a_number_flag, any_signaling_not_a_number_flag, add_op;
   logic sa, sb, sx, swap, exact_zero, special, inexact, underflow_flag, overflow_flag, invalid_operation_flag, inc, rb, stk, tiny_up;
   logic signed [17:0] ea, eb, ex, emin, emax, dlt, shs;
   logic [63:0] ma, mb;
   logic [6:0] p, lsb_pos, d, sh, lz;
   logic [67:0] wa, wb, wsh, sum, keep, rsum, lowmask;
   logic [66:0] w;
   logic [81:0] na, nb;
   fpp_pkg::fpp_cc_t cc;
   logic req, wr_now;
   logic [31:0] rd;

   always_comb
   begin
      s_d = s_q;
      src = op_in.src;
      dst = op_in.dst;
      res_v = '0;
      {special, inexact, underflow_flag, overflow_flag, invalid_operation_flag, inc, rb, stk, exact_zero, tiny_up} = '0;
      {sa, sb, sx, swap} = '0;
      {ea, eb, ex, dlt, shs} = '0;
      {ma, mb, d, sh, lz} = '0;
      {wa, wb, wsh, sum, keep, rsum, lowmask, w, na, nb} = '0;
      add_op = (op_in.code == fpp_pkg::float_add_instruction);
      case (s_q.prec)
         fpp_pkg::PREC_SGL:
         begin
            p = fpp_pkg::PREC_BITS_SGL;
            emin = fpp_pkg::EMIN_SGL;
            emax = fpp_pkg::EMAX_SGL;
         end
         fpp_pkg::PREC_DBL:
         begin
            p = fpp_pkg::PREC_BITS_DBL;
            emin = fpp_pkg::EMIN_DBL;
            emax = fpp_pkg::EMAX_DBL;
         end
         default:
         begin
            p = fpp_pkg::PREC_BITS_EXT;
            emin = fpp_pkg::EMIN_EXT;
            emax = fpp_pkg::EMAX_EXT;
         end
      endcase
      lsb_pos = 7'h43 - p;

      // signaling operands: flag, then quiet them whether or not trapping
      src_signaling_not_a_number_flag = is_nan(src) && !src.mant[fpp_pkg::QUIET_BIT];
      dst_signaling_not_a_number_flag = add_op && is_nan(dst) && !dst.mant[fpp_pkg::QUIET_BIT];
      any_signaling_not_a_number_flag = (op_in.code != fpp_pkg::OP_MOVE_RAW) && (src_signaling_not_a_number_flag || dst_signaling_not_a_number_flag);
      src.mant[fpp_pkg::QUIET_BIT] = src.mant[fpp_pkg::QUIET_BIT] | src_signaling_not_a_number_flag;
      dst.mant[fpp_pkg::QUIET_BIT] = dst.mant[fpp_pkg::QUIET_BIT] | dst_signaling_not_a_number_flag;
      src_nan = is_nan(src);
      dst_nan = add_op && is_nan(dst);

      if (op_in.code == fpp_pkg::OP_MOVE_RAW)
      begin
         res_v = op_in.src;
         special = 1'b1;
      end
      else if (src_nan && dst_nan)
      begin
         res_v = dst;
         special = 1'b1;
      end
      else if (src_nan || dst_nan)
      begin
         res_v = src_nan ? src : dst;
         special = 1'b1;
      end
      else if (add_op && is_inf(src) && is_inf(dst) && (src.sign != dst.sign))
      begin
         res_v = '{1'b0, fpp_pkg::EXP_ALL_ONES, fpp_pkg::DEFAULT_NAN_MANT};
         invalid_operation_flag = 1'b1;
         special = 1'b1;
      end
      else if (is_inf(src) || (add_op && is_inf(dst)))
      begin
         res_v = is_inf(src) ? src : dst;
         special = 1'b1;
      end
      else if (add_op && is_zero(src) && is_zero(dst))
      begin
         res_v.sign = (src.sign == dst.sign) ? src.sign : (s_q.mode == fpp_pkg::round_toward_minus);
         special = 1'b1;
      end
      else if (!add_op && is_zero(src))
      begin
         res_v.sign = src.sign;
         special = 1'b1;
      end
      else
      begin
         na = norm_op(src);
         nb = add_op ? norm_op(dst) : {18'sh20000, 64'h0};
         swap = $signed(nb[81:64]) > $signed(na[81:64]);
         {ea, ma, sa} = swap ? {nb, dst.sign} : {na, src.sign};
         {eb, mb, sb} = swap ? {na, src.sign} : {nb, dst.sign};
         dlt = ea - eb;
         d = (dlt > 18'sh00043) ? 7'h44 : dlt[6:0];
         wa = {1'b0, ma, 3'h0};
         wb = {1'b0, mb, 3'h0};
         lowmask = ~(68'hF_FFFF_FFFF_FFFF_FFFF << d);
         wsh = (wb >> d) | {67'h0, |(wb & lowmask)};
         if (sa == sb)
         begin
            sum = wa + wsh;
            sx = sa;
         end
         else if (wa >= wsh)
         begin
            sum = wa - wsh;
            sx = sa;
         end
         else
         begin
            sum = wsh - wa;
            sx = sb;
         end
         if (sum == 68'h0)
         begin
            exact_zero = 1'b1;
            res_v.sign = (sa == sb) ? sa : (s_q.mode == fpp_pkg::round_toward_minus);
         end
         else if (sum[67])
         begin
            w = {sum[67:2], sum[1] | sum[0]};
            ex = ea + 18'sh00001;
         end
         else
         begin
            lz = 7'(lzc68(sum) - 7'h01);
            w = 67'(sum[66:0] << lz);
            ex = ea - $signed({11'h000, lz});
         end
      end

      // post-processing on the wide result: underflow, round, overflow
      if (!special && !exact_zero)
      begin
         if (ex < emin)
         begin
            underflow_flag = 1'b1;
            shs = emin - ex;
            sh = (shs > 18'sh00043) ? 7'h44 : shs[6:0];
            ex = emin;
            if (sh > p)
            begin
               tiny_up = ((s_q.mode == fpp_pkg::round_toward_plus) && !sx) ||
                         ((s_q.mode == fpp_pkg::round_toward_minus) && sx);
               w = tiny_up ? 67'(67'h1 << lsb_pos) : 67'h0;
               inexact = 1'b1;
            end
            else
            begin
               lowmask = ~(68'hF_FFFF_FFFF_FFFF_FFFF << sh);
               w = 67'(({1'b0, w} >> sh) | {67'h0, |({1'b0, w} & lowmask)});
            end
         end
         lowmask = (68'h1 << (lsb_pos - 7'h01)) - 68'h1;
         rb = w[lsb_pos - 7'h01];
         stk = |({1'b0, w} & lowmask);
         keep = {1'b0, w} & (68'hF_FFFF_FFFF_FFFF_FFFF << lsb_pos);
         inexact = inexact | rb | stk;
         case (s_q.mode)
            fpp_pkg::round_to_nearest: inc = rb && (stk || w[lsb_pos]);
            fpp_pkg::round_toward_plus: inc = (rb || stk) && !sx;
            fpp_pkg::round_toward_minus: inc = (rb || stk) && sx;
            default: inc = 1'b0;
         endcase
         rsum = keep + (inc ? (68'h1 << lsb_pos) : 68'h0);
         if (rsum[67])
         begin
            ma = rsum[67:4];
            ex = ex + 18'sh00001;
         end
         else
         begin
            ma = rsum[66:3];
         end
         if (ex > emax)
         begin
            overflow_flag = 1'b1;
            inexact = 1'b1;
            if ((s_q.mode == fpp_pkg::round_to_nearest) ||
                ((s_q.mode == fpp_pkg::round_toward_plus) && !sx) ||
                ((s_q.mode == fpp_pkg::round_toward_minus) && sx))
            begin
               res_v = '{sx, fpp_pkg::EXP_ALL_ONES, 64'h0};
            end
            else
            begin
               res_v = '{sx, emax[14:0], 64'(64'hFFFF_FFFF_FFFF_FFFF << (7'h40 - p))};
            end
         end
         else
         begin
            res_v.sign = sx;
            res_v.mant = ma;
            res_v.exp = (!ma[63] && ((ex == 18'sh00001) || (ma == 64'h0))) ? 15'h0000 : ex[14:0];
         end
      end

      // condition bits from the value alone
      cc.n = res_v.sign;
      cc.z = is_zero(res_v);
      cc.i = is_inf(res_v);
      cc.nan = is_nan(res_v);

      s_d.res.valid = op_in.valid;
      s_d.res.write = 1'b0;
      s_d.res.trap = 1'b0;
      if (op_in.valid)
      begin
         if (any_signaling_not_a_number_flag && s_q.signaling_not_a_number_flag_trap_en)
         begin
            s_d.res.trap = 1'b1;
         end
         else
         begin
            s_d.res.write = 1'b1;
            s_d.res.value = res_v;
            s_d.res.cc = cc;
            s_d.cc = cc;
         end
      end

      // avalon slave: one wait cycle, then the access completes
      req = avs_read_in || avs_write_in;
      wr_now = avs_write_in && !s_q.waitreq;
      s_d.waitreq = !(req && s_q.waitreq);
      rd = 32'h0000_0000;
      if (avs_address_in == fpp_pkg::ADDR_CTRL)
      begin
         rd[fpp_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
         rd[fpp_pkg::CTRL_PREC_LSB +: 2] = s_q.prec;
         rd[fpp_pkg::CTRL_SIGNALING_NOT_A_NUMBER_FLAG_TRAP_BIT] = s_q.signaling_not_a_number_flag_trap_en;
      end
      else if (avs_address_in == fpp_pkg::ADDR_STAT)
      begin
         rd[fpp_pkg::STAT_INEX_BIT] = s_q.inex_flag;
         rd[fpp_pkg::STAT_UNDERFLOW_FLAG_BIT] = s_q.underflow_flag_flag;
         rd[fpp_pkg::STAT_OVERFLOW_FLAG_BIT] = s_q.overflow_flag_flag;
         rd[fpp_pkg::STAT_INVALID_OPERATION_FLAG_BIT] = s_q.invalid_operation_flag_flag;
         rd[fpp_pkg::STAT_SIGNALING_NOT_A_NUMBER_FLAG_BIT] = s_q.signaling_not_a_number_flag_flag;
         rd[fpp_pkg::STAT_CC_LSB +: 4] = s_q.cc;
      end
      if (avs_read_in && s_q.waitreq)
      begin
         s_d.rdata = rd;
      end
      if (wr_now && (avs_address_in == fpp_pkg::ADDR_CTRL))
      begin
         if (avs_byteenable_in[0])
         begin
            s_d.mode = fpp_pkg::fpp_rnd_t'(avs_writedata_in[fpp_pkg::CTRL_MODE_LSB +: 2]);
            s_d.prec = fpp_pkg::fpp_prec_t'(avs_writedata_in[fpp_pkg::CTRL_PREC_LSB +: 2]);
         end
         if (avs_byteenable_in[1])
         begin
            s_d.signaling_not_a_number_flag_trap_en = avs_writedata_in[fpp_pkg::CTRL_SIGNALING_NOT_A_NUMBER_FLAG_TRAP_BIT];
         end
      end
      // write one to clear sticky faults; a new event in the same cycle wins
      if (wr_now && (avs_address_in == fpp_pkg::ADDR_STAT) && avs_byteenable_in[1])
      begin
         s_d.inex_flag = s_d.inex_flag & ~avs_writedata_in[fpp_pkg::STAT_INEX_BIT];
         s_d.underflow_flag_flag = s_d.underflow_flag_flag & ~avs_writedata_in[fpp_pkg::STAT_UNDERFLOW_FLAG_BIT];
         s_d.overflow_flag_flag = s_d.overflow_flag_flag & ~avs_writedata_in[fpp_pkg::STAT_OVERFLOW_FLAG_BIT];
         s_d.invalid_operation_flag_flag = s_d.invalid_operation_flag_flag & ~avs_writedata_in[fpp_pkg::STAT_INVALID_OPERATION_FLAG_BIT];
         s_d.signaling_not_a_number_flag_flag = s_d.signaling_not_a_number_flag_flag & ~avs_writedata_in[fpp_pkg::STAT_SIGNALING_NOT_A_NUMBER_FLAG_BIT];
      end
      if (op_in.valid)
      begin
         s_d.signaling_not_a_number_flag_flag = s_d.signaling_not_a_number_flag_flag | any_signaling_not_a_number_flag;
         if (!(any_signaling_not_a_number_flag && s_q.signaling_not_a_number_flag_trap_en))
         begin
            s_d.invalid_operation_flag_flag = s_d.invalid_operation_flag_flag | invalid_operation_flag;
            s_d.underflow_flag_flag = s_d.underflow_flag_flag | underflow_flag;
            s_d.overflow_flag_flag = s_d.overflow_flag_flag | overflow_flag;
            s_d.inex_flag = s_d.inex_flag | inexact;
         end
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         s_q <= '0;
         s_q.waitreq <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign res_out = s_q.res;
   assign avs_readdata_out = s_q.rdata;
   assign avs_waitrequest_out = s_q.waitreq;

endmodule // fpp_core

// ---- hw/fpp_pkg.sv ----
package fpp_pkg;

   // register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PREC_LSB = 2;
   localparam int CTRL_SIGNALING_NOT_A_NUMBER_FLAG_TRAP_BIT = 8;

   // status register fields: sticky fault byte in byte 1, condition bits in byte 3
   localparam int STAT_INEX_BIT = 9;
   localparam int STAT_UNDERFLOW_FLAG_BIT = 11;
   localparam int STAT_OVERFLOW_FLAG_BIT = 12;
   localparam int STAT_INVALID_OPERATION_FLAG_BIT = 13;
   localparam int STAT_SIGNALING_NOT_A_NUMBER_FLAG_BIT = 14;
   localparam int STAT_FAULT_LSB = 8;
   localparam int STAT_CC_LSB = 24;

   // extended format
   localparam logic [14:0] EXP_ALL_ONES = 15'h7FFF;
   localparam int QUIET_BIT = 62;
   localparam logic [63:0] DEFAULT_NAN_MANT = 64'hFFFF_FFFF_FFFF_FFFF;

   // precision widths in bits, and exponent limits as biased extended exponents
   localparam logic [6:0] PREC_BITS_EXT = 7'h40;
   localparam logic [6:0] PREC_BITS_DBL = 7'h35;
   localparam logic [6:0] PREC_BITS_SGL = 7'h18;
   localparam logic signed [17:0] EMIN_EXT = 18'sh00001;
   localparam logic signed [17:0] EMIN_DBL = 18'sh03C01;
   localparam logic signed [17:0] EMIN_SGL = 18'sh03F81;
   localparam logic signed [17:0] EMAX_EXT = 18'sh07FFE;
   localparam logic signed [17:0] EMAX_DBL = 18'sh043FE;
   localparam logic signed [17:0] EMAX_SGL = 18'sh0407E;

   typedef enum logic [1:0] {round_to_nearest, round_toward_zero, round_toward_minus, round_toward_plus} fpp_rnd_t;
   typedef enum logic [1:0] {PREC_EXT, PREC_SGL, PREC_DBL, PREC_RSV} fpp_prec_t;
   typedef enum logic [1:0] {float_add_instruction, OP_MOVE, OP_MOVE_RAW, OP_RSV} fpp_opc_t;

   typedef struct packed {
      logic sign;
      logic [14:0] exp;
      logic [63:0] mant;
   } fpp_ext_t;

   typedef struct packed {
      logic n;
      logic z;
      logic i;
      logic nan;
   } fpp_cc_t;

   typedef struct packed {
      logic valid;
      fpp_opc_t code;
      fpp_ext_t src;
      fpp_ext_t dst;
   } fpp_op_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic trap;
      fpp_cc_t cc;
      fpp_ext_t value;
   } fpp_res_t;

   typedef struct packed {
      fpp_rnd_t mode;
      fpp_prec_t prec;
      logic signaling_not_a_number_flag_trap_en;
      logic signaling_not_a_number_flag_flag;
      logic invalid_operation_flag_flag;
      logic overflow_flag_flag;
      logic underflow_flag_flag;
      logic inex_flag;
      fpp_cc_t cc;
      logic waitreq;
      logic [31:0] rdata;
      fpp_res_t res;
   } fpp_state_t;

endpackage

// ---- sim/fpp_core_properties.sv ----
`timescale 1ns/100ps
module fpp_core_properties
(
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire fpp_pkg::fpp_op_t op_in,
   input wire fpp_pkg::fpp_res_t res_out,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   wire logic add_op = op_in.valid && op_in.code == fpp_pkg::float_add_instruction;
   wire logic src_qn = op_in.src.exp == 15'h7FFF && op_in.src.mant[62];
   wire logic dst_qn = op_in.dst.exp == 15'h7FFF && op_in.dst.mant[62];
   wire logic src_sg = op_in.src.exp == 15'h7FFF && !op_in.src.mant[62] && op_in.src.mant[61:0] != '0;
   wire logic dst_any = op_in.dst.exp == 15'h7FFF && op_in.dst.mant[62:0] != '0;
   wire logic r_top = res_out.value.exp == 15'h7FFF;
   wire logic r_frac = res_out.value.mant[62:0] != '0;
   sequence s_bus_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_ack_pulse;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   chk_res_pulse: assert property (op_in.valid |=> res_out.valid && (res_out.write ^ res_out.trap))
      else $error("operation gave no single result pulse");
   chk_no_spurious: assert property (!op_in.valid |=> !res_out.valid && !res_out.write && !res_out.trap)
      else $error("result pulse without operation");
   chk_zero_sum: assert property (add_op && op_in.src == '0 && op_in.dst == '0 |=> res_out.value == '0)
      else $error("two plus zeros did not sum to plus zero");
   chk_inf_cancel: assert property (add_op && op_in.src.exp == 15'h7FFF && op_in.src.mant[62:0] == '0
      && op_in.dst.exp == 15'h7FFF && op_in.dst.mant[62:0] == '0 && (op_in.src.sign != op_in.dst.sign)
      |=> res_out.write && r_top && r_frac)
      else $error("opposite infinities did not give a nan");
   chk_one_quiet: assert property (add_op && src_qn && !dst_any |=> res_out.value == $past(op_in.src))
      else $error("single quiet nan not passed through");
   chk_two_quiet: assert property (add_op && src_qn && dst_qn |=> res_out.value == $past(op_in.dst))
      else $error("two quiet nans did not return destination");
   chk_sig_path: assert property (add_op && src_sg && !dst_any |=> res_out.trap
      || (res_out.write && res_out.value == ($past(op_in.src) | 80'h0000_4000_0000_0000_0000)))
      else $error("signaling operand neither trapped nor quieted");
   chk_trap_hold: assert property (res_out.trap |-> !res_out.write && $stable(res_out.value))
      else $error("trap modified the destination");
   chk_raw_move: assert property (op_in.valid && op_in.code == fpp_pkg::OP_MOVE_RAW
      |=> res_out.write && res_out.value == $past(op_in.src))
      else $error("raw move altered its operand");
   chk_cc_value: assert property (res_out.write |-> res_out.cc == {res_out.value.sign,
      !r_top && res_out.value.mant == '0, r_top && !r_frac, r_top && r_frac})
      else $error("condition bits do not match result");
   chk_ack_once: assert property (s_bus_req |=> s_ack_pulse)
      else $error("bus access not answered in one cycle");
   chk_idle_wait: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
      else $error("bus answered without request");
endmodule // fpp_core_properties
bind fpp_core fpp_core_properties fpp_core_properties_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
   .op_in(op_in), .res_out(res_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

// ---- sim/fpp_core_tb.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end
module fpp_core_tb;
   localparam logic [63:0] MSB = 64'h8000_0000_0000_0000;
   localparam fpp_pkg::fpp_ext_t ONE = {1'b0, 15'h3FFF, MSB};
   localparam fpp_pkg::fpp_ext_t PINF = {1'b0, 15'h7FFF, MSB};
   localparam fpp_pkg::fpp_ext_t NINF = {1'b1, 15'h7FFF, MSB};
   localparam fpp_pkg::fpp_ext_t BIG = {1'b0, 15'h7FFE, 64'hFFFF_FFFF_FFFF_FFFF};
   localparam fpp_pkg::fpp_ext_t SIG = {1'b0, 15'h7FFF, 64'h8000_0000_0000_0001};
   localparam fpp_pkg::fpp_ext_t TINY = {1'b0, 15'h0001, MSB};
   localparam fpp_pkg::fpp_ext_t SMALL = {1'b0, 15'h3FE1, MSB};
   localparam logic [31:0] F_INX = 32'h0000_0200;
   localparam logic [31:0] F_UNF = 32'h0000_0800;
   localparam logic [31:0] F_OVF = 32'h0000_1000;
   logic clk_sys_in;
   logic srst_in;
   fpp_pkg::fpp_op_t op_in;
   fpp_pkg::fpp_res_t res_out;
   logic [3:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [31:0] avs_writedata_in;
   logic [3:0] avs_byteenable_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   int mismatches;
   int num_checks;
   int cycles;
   int m;
   logic [31:0] rd;
   fpp_pkg::fpp_cc_t model_cc;
   fpp_pkg::fpp_ext_t model_val;
   fpp_pkg::fpp_ext_t a;
   fpp_pkg::fpp_ext_t b;

   fpp_core fpp_core_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .op_in(op_in), .res_out(res_out),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         final_report();
      end
   end

   task final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   function fpp_pkg::fpp_cc_t cc_of(input fpp_pkg::fpp_ext_t v);
      cc_of = {v.sign, v.exp != 15'h7FFF && v.mant == '0, v.exp == 15'h7FFF && v.mant[62:0] == '0,
         v.exp == 15'h7FFF && v.mant[62:0] != '0};
   endfunction

   // request held until waitrequest is seen low, then released with one idle edge
   task bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] be);
      avs_read_in <= !wr;
      avs_write_in <= wr;
      avs_address_in <= ad;
      avs_writedata_in <= wd;
      avs_byteenable_in <= be;
      do
      begin
         @(posedge clk_sys_in);
      end
      while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   task set_ctl(input int md, input int pr, input logic tr);
      bus(1'b1, fpp_pkg::ADDR_CTRL, (32'(tr) << 8) | (32'(pr) << 2) | 32'(md), 4'h3);
   endtask

   task run(input fpp_pkg::fpp_opc_t c, input fpp_pkg::fpp_ext_t s, input fpp_pkg::fpp_ext_t d,
      input fpp_pkg::fpp_ext_t ev, input logic tr, input logic [31:0] fl);
      logic [79:0] msk;
      op_in <= {1'b1, c, s, d};
      @(posedge clk_sys_in);
      op_in <= '0;
      @(posedge clk_sys_in);
      `CHK("valid", 1'b1, res_out.valid)
      `CHK("trap", tr, res_out.trap)
      `CHK("write", !tr, res_out.write)
      if (!tr)
      begin
         model_val = ev;
         model_cc = cc_of(ev);
      end
      // integer bit of an infinity is left open
      msk = (ev.exp == 15'h7FFF && ev.mant[62:0] == '0) ? ~(80'h1 << 63) : '1;
      `CHK("value", model_val & msk, res_out.value & msk)
      `CHK("cc", model_cc, res_out.cc)
      bus(1'b0, fpp_pkg::ADDR_STAT, '0, 4'hF);
      `CHK("status", fl | {4'h0, model_cc, 24'h0}, rd)
      bus(1'b1, fpp_pkg::ADDR_STAT, 32'h0000_7E00, 4'h2);
   endtask

   initial
   begin
      srst_in = 1'b1;
      op_in = '0;
      avs_address_in = '0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = '0;
      avs_byteenable_in = '0;
      model_cc = '0;
      model_val = '0;
      void'($urandom(32'h07220e9c));
      repeat (6) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      bus(1'b0, fpp_pkg::ADDR_CTRL, '0, 4'hF);
      `CHK("ctrl reset", 32'h0, rd)
      bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 4'h8, '0, 4'hF);
      `CHK("unmapped", 32'h0, rd)
      bus(1'b0, fpp_pkg::ADDR_CTRL, '0, 4'hF);
      `CHK("ctrl kept", 32'h0, rd)
      $display("registers done");
      run(fpp_pkg::float_add_instruction, '0, '0, '0, 1'b0, '0);
      for (m = 0; m < 4; m++)
      begin
         set_ctl(m, 0, 1'b0);
         run(fpp_pkg::float_add_instruction, '0, {1'b1, 79'h0}, {m == 2, 79'h0}, 1'b0, '0);
      end
      set_ctl(0, 0, 1'b0);
      run(fpp_pkg::float_add_instruction, PINF, NINF, {16'h7FFF, 64'hFFFF_FFFF_FFFF_FFFF}, 1'b0,
         32'h0000_2000);
      $display("zeros and infinities done");
      a = {1'($urandom), 15'h7FFF, {$urandom, $urandom} | 64'h4000_0000_0000_0000};
      b = {1'($urandom), 15'h7FFF, {$urandom, $urandom} | 64'h4000_0000_0000_0000};
      run(fpp_pkg::float_add_instruction, a, ONE, a, 1'b0, '0);
      run(fpp_pkg::float_add_instruction, ONE, b, b, 1'b0, '0);
      run(fpp_pkg::float_add_instruction, a, b, b, 1'b0, '0);
      run(fpp_pkg::float_add_instruction, SIG, ONE, SIG | 80'h0000_4000_0000_0000_0000, 1'b0,
         32'h0000_4000);
      set_ctl(0, 0, 1'b1);
      run(fpp_pkg::float_add_instruction, ONE, SIG, '0, 1'b1, 32'h0000_4000);
      run(fpp_pkg::OP_MOVE_RAW, SIG, '0, SIG, 1'b0, '0);
      set_ctl(0, 0, 1'b0);
      $display("nan handling done");
      for (m = 0; m < 8; m++)
      begin
         a = {1'($urandom), 15'(15'h0001 + $urandom_range(32'h7FFC)), MSB | {$urandom, $urandom}};
         run(fpp_pkg::OP_MOVE, a, '0, a, 1'b0, '0);
      end
      run(fpp_pkg::OP_MOVE, NINF, '0, NINF, 1'b0, '0);
      $display("moves done");
      set_ctl(0, 1, 1'b0);
      run(fpp_pkg::float_add_instruction, ONE, SMALL, ONE, 1'b0, F_INX);
      set_ctl(3, 1, 1'b0);
      run(fpp_pkg::float_add_instruction, ONE, SMALL, {16'h3FFF, 64'h8000_0100_0000_0000}, 1'b0, F_INX);
      set_ctl(0, 2, 1'b0);
      run(fpp_pkg::float_add_instruction, ONE, SMALL, {16'h3FFF, 64'h8000_0002_0000_0000}, 1'b0, '0);
      run(fpp_pkg::OP_RSV, ONE, '0, ONE, 1'b0, '0);
      set_ctl(0, 0, 1'b0);
      run(fpp_pkg::float_add_instruction, BIG, BIG, PINF, 1'b0, F_OVF | F_INX);
      set_ctl(1, 0, 1'b0);
      run(fpp_pkg::float_add_instruction, BIG, BIG, BIG, 1'b0, F_OVF | F_INX);
      $display("rounding and overflow done");
      set_ctl(0, 0, 1'b0);
      run(fpp_pkg::float_add_instruction, {16'h0001, 64'hC000_0000_0000_0000}, {1'b1, 15'h0001, MSB},
         {16'h0000, 64'h4000_0000_0000_0000}, 1'b0, F_UNF);
      set_ctl(0, 1, 1'b0);
      run(fpp_pkg::float_add_instruction, TINY, '0, '0, 1'b0, F_UNF | F_INX);
      set_ctl(3, 1, 1'b0);
      run(fpp_pkg::float_add_instruction, TINY, '0, {16'h3F81, 64'h0000_0100_0000_0000}, 1'b0,
         F_UNF | F_INX);
      $display("underflow done");
      final_report();
   end
endmodule // fpp_core_tb
